// >>> hdl/ccpc_pkg.sv
package ccpc_pkg;
    localparam int          OSC_FREQ_HZ       = 32768;
    localparam logic [10:0] PLL_MULT_VAL      = 11'h560;
    localparam int          PLL_FREQ_HZ       = OSC_FREQ_HZ * 1376;

    localparam logic [7:0]  ADDR_CLK_KEY1     = 8'h00;
    localparam logic [7:0]  ADDR_PLL_CONFIG   = 8'h04;
    localparam logic [7:0]  ADDR_CLK_KEY2     = 8'h08;
    localparam logic [7:0]  ADDR_PWR_KEY      = 8'h0c;
    localparam logic [7:0]  ADDR_PWR_CONFIG   = 8'h10;
    localparam logic [7:0]  ADDR_STATUS       = 8'h14;

    localparam logic [7:0]  CLK_KEY1_VAL      = 8'haa;
    localparam logic [7:0]  CLK_KEY2_VAL      = 8'h55;
    localparam logic [7:0]  PWR_KEY1_VAL      = 8'h01;
    localparam logic [7:0]  PWR_KEY2_VAL      = 8'hf4;

    localparam int          MODE_LSB          = 0;
    localparam int          WDOG_BIT          = 2;
    localparam int          DIV_LSB           = 0;
    localparam int          FAST_IRQ_BOOST_BIT          = 3;
    localparam int          OPMODE_LSB        = 4;

    localparam logic [1:0]  MODE_PLL          = 2'h1;
    localparam logic [1:0]  MODE_EXT_CLK      = 2'h3;
    localparam logic [2:0]  OPMODE_NORMAL     = 3'h0;
    localparam logic [2:0]  OPMODE_POWER_DOWN = 3'h1;

    localparam logic [1:0]  MODE_RESET        = MODE_PLL;
    localparam logic        WDOG_RESET        = 1'b0;
    localparam logic [2:0]  DIV_RESET         = 3'h3;
    localparam logic        FAST_IRQ_BOOST_RESET        = 1'b0;
    localparam logic [2:0]  OPMODE_RESET      = OPMODE_NORMAL;

    typedef enum logic [2:0] {
        KEY_IDLE,
        KEY_CLK_OPEN,
        KEY_CLK_HELD,
        KEY_PWR_OPEN,
        KEY_PWR_HELD
    } ccpc_key_e;
endpackage : ccpc_pkg

// >>> hdl/ccpc_div_if.sv
interface ccpc_div_if;
    logic [2:0] div_code;
    logic       run;
    logic       ext_mode;
    logic       ext_clk;
    logic       tick;
    logic       clk_pin;

    modport ctrl (output div_code, output run, output ext_mode, output ext_clk, input tick, input clk_pin);
    modport div  (input div_code, input run, input ext_mode, input ext_clk, output tick, output clk_pin);
endinterface : ccpc_div_if

// >>> hdl/ccpc_divider.sv
module ccpc_divider
    import ccpc_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    ccpc_div_if.div     dif
);
    logic [6:0] cnt_ff;
    logic [6:0] nxt_cnt;
    logic       ext_prev_ff;
    logic       nxt_ext_prev;
    logic       tick_ff;
    logic       nxt_tick;
    logic       pin_ff;
    logic       nxt_pin;
    logic       src_edge;
    logic [6:0] mask;
    logic [2:0] pin_idx;

    assign dif.tick    = tick_ff;
    assign dif.clk_pin = pin_ff;

    always_comb begin
        // source edge: every clk in pll mode, a rising edge of the external pin otherwise
        src_edge     = dif.ext_mode ? (dif.ext_clk & ~ext_prev_ff) : 1'b1;
        nxt_ext_prev = dif.ext_clk;
        mask         = 7'((8'h01 << dif.div_code) - 8'h01);
        pin_idx      = 3'(dif.div_code - 3'h1);
        nxt_cnt      = cnt_ff;
        nxt_tick     = 1'b0;
        nxt_pin      = 1'b0;
        if (dif.run && src_edge) begin
            nxt_cnt  = 7'(cnt_ff + 7'h01) & mask;
            nxt_tick = ((cnt_ff & mask) == mask);
        end
        if (dif.run) begin
            // square wave at the core rate; at full speed the pin shows the tick itself
            nxt_pin = (dif.div_code == 3'h0) ? src_edge : nxt_cnt[pin_idx];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff      <= 7'h00;
            ext_prev_ff <= 1'b0;
            tick_ff     <= 1'b0;
            pin_ff      <= 1'b0;
        end else begin
            cnt_ff      <= nxt_cnt;
            ext_prev_ff <= nxt_ext_prev;
            tick_ff     <= nxt_tick;
            pin_ff      <= nxt_pin;
        end
    end

    // the pulse cycle itself must already run at divide by eight, else the count restarts late
    sequence s_div8_steady;
        (dif.run && !dif.ext_mode && dif.div_code == 3'h3) [*7];
    endsequence

    a_div_eight_period: assert property (@(posedge clk) disable iff (rst)
        (tick_ff && dif.run && !dif.ext_mode && dif.div_code == 3'h3) ##1 s_div8_steady |=> tick_ff)
        else $error("core tick period wrong for divide by eight");

    a_pin_stops_idle: assert property (@(posedge clk) disable iff (rst)
        !dif.run |=> !pin_ff && !tick_ff)
        else $error("clock pin or tick active while stopped");
endmodule : ccpc_divider

// >>> hdl/ccpc_top.sv
module ccpc_top
    import ccpc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        EXTERNAL_CLOCK_INPUT,
    input  wire logic        EXT_INT_LINE_0,
    input  wire logic        EXT_INT_LINE_1,
    input  wire logic        TIMER2_WAKE,
    input  wire logic        TIMER3_WAKE,
    input  wire logic        IRQ_IN_SERVICE,
    output logic             CORE_CLK_EN,
    output logic             CLOCK_OUT_PIN,
    output logic      [1:0]  CLOCK_SOURCE_MODE,
    output logic             WATCHDOG_SLOW_SOURCE,
    output logic             PLL_ENABLE,
    output logic      [10:0] PLL_MULT,
    output logic             POWERED_DOWN
);
    ccpc_key_e  key_ff;
    ccpc_key_e  nxt_key;
    logic [7:0] pend_ff;
    logic [7:0] nxt_pend;

    logic [1:0] mode_ff;
    logic [1:0] nxt_mode;
    logic       wdog_ff;
    logic       nxt_wdog;
    logic [2:0] div_ff;
    logic [2:0] nxt_div;
    logic       fast_irq_boost_ff;
    logic       nxt_fast_irq_boost;
    logic [2:0] opmode_ff;
    logic [2:0] nxt_opmode;

    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    logic       acc;
    logic       acc_wr;
    logic [7:0] wbyte;
    logic       mapped;
    logic       clk_commit;
    logic       pwr_commit;
    logic       power_down;
    logic       wake;
    logic       boost;
    logic [2:0] div_eff;
    logic [7:0] pll_view;
    logic [7:0] pwr_view;
    logic [7:0] status_view;

    ccpc_div_if dif ();

    ccpc_divider u_div (
        .clk (CLK),
        .rst (SYS_RST),
        .dif (dif.div)
    );

    // apb slave with no wait states
    assign acc    = PSEL & PENABLE;
    assign acc_wr = acc & PWRITE;
    assign wbyte  = PWDATA[7:0];
    assign mapped = (PADDR == ADDR_CLK_KEY1) || (PADDR == ADDR_PLL_CONFIG) || (PADDR == ADDR_CLK_KEY2)
                 || (PADDR == ADDR_PWR_KEY) || (PADDR == ADDR_PWR_CONFIG) || (PADDR == ADDR_STATUS);

    assign PREADY  = 1'b1;
    assign PSLVERR = acc & ~mapped;
    assign PRDATA  = rdata_ff;

    // key sequencer: any access other than the next expected one aborts
    always_comb begin
        nxt_key    = key_ff;
        nxt_pend   = pend_ff;
        clk_commit = 1'b0;
        pwr_commit = 1'b0;
        if (acc) begin
            nxt_key = KEY_IDLE;
            case (key_ff)
                KEY_CLK_OPEN: begin
                    if (acc_wr && PADDR == ADDR_PLL_CONFIG) begin
                        nxt_key  = KEY_CLK_HELD;
                        nxt_pend = wbyte;
                    end
                end
                KEY_CLK_HELD: begin
                    clk_commit = acc_wr && PADDR == ADDR_CLK_KEY2 && wbyte == CLK_KEY2_VAL;
                end
                KEY_PWR_OPEN: begin
                    if (acc_wr && PADDR == ADDR_PWR_CONFIG) begin
                        nxt_key  = KEY_PWR_HELD;
                        nxt_pend = wbyte;
                    end
                end
                KEY_PWR_HELD: begin
                    pwr_commit = acc_wr && PADDR == ADDR_PWR_KEY && wbyte == PWR_KEY2_VAL;
                end
                default: begin
                    nxt_key = KEY_IDLE;
                end
            endcase
            // an aborting access may itself open a fresh sequence
            if (nxt_key == KEY_IDLE && !clk_commit && !pwr_commit && acc_wr) begin
                if (PADDR == ADDR_CLK_KEY1 && wbyte == CLK_KEY1_VAL) begin
                    nxt_key = KEY_CLK_OPEN;
                end else if (PADDR == ADDR_PWR_KEY && wbyte == PWR_KEY1_VAL) begin
                    nxt_key = KEY_PWR_OPEN;
                end
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            key_ff  <= KEY_IDLE;
            pend_ff <= 8'h00;
        end else begin
            key_ff  <= nxt_key;
            pend_ff <= nxt_pend;
        end
    end

    // configuration registers, loaded at the closing key write; a wake source also clears the operating mode
    always_comb begin
        nxt_mode   = mode_ff;
        nxt_wdog   = wdog_ff;
        nxt_div    = div_ff;
        nxt_fast_irq_boost   = fast_irq_boost_ff;
        nxt_opmode = opmode_ff;
        if (clk_commit) begin
            nxt_wdog = pend_ff[WDOG_BIT];
            // reserved mode codes leave the running mode untouched
            if (pend_ff[MODE_LSB +: 2] == MODE_PLL || pend_ff[MODE_LSB +: 2] == MODE_EXT_CLK) begin
                nxt_mode = pend_ff[MODE_LSB +: 2];
            end
        end
        if (wake) begin
            nxt_opmode = OPMODE_NORMAL;
        end
        if (pwr_commit) begin
            nxt_div  = pend_ff[DIV_LSB +: 3];
            nxt_fast_irq_boost = pend_ff[FAST_IRQ_BOOST_BIT];
            if (pend_ff[OPMODE_LSB +: 3] == OPMODE_NORMAL || pend_ff[OPMODE_LSB +: 3] == OPMODE_POWER_DOWN) begin
                nxt_opmode = pend_ff[OPMODE_LSB +: 3];
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mode_ff   <= MODE_RESET;
            wdog_ff   <= WDOG_RESET;
            div_ff    <= DIV_RESET;
            fast_irq_boost_ff   <= FAST_IRQ_BOOST_RESET;
            opmode_ff <= OPMODE_RESET;
        end else begin
            mode_ff   <= nxt_mode;
            wdog_ff   <= nxt_wdog;
            div_ff    <= nxt_div;
            fast_irq_boost_ff   <= nxt_fast_irq_boost;
            opmode_ff <= nxt_opmode;
        end
    end

    // clock steering
    assign power_down = (opmode_ff == OPMODE_POWER_DOWN);
    assign wake       = power_down & (EXT_INT_LINE_0 | EXT_INT_LINE_1 | TIMER2_WAKE | TIMER3_WAKE);
    assign boost      = fast_irq_boost_ff & IRQ_IN_SERVICE;
    assign div_eff    = boost ? 3'h0 : div_ff;

    assign dif.div_code = div_eff;
    assign dif.run      = ~power_down;
    assign dif.ext_mode = (mode_ff == MODE_EXT_CLK);
    assign dif.ext_clk  = EXTERNAL_CLOCK_INPUT;

    assign CORE_CLK_EN          = dif.tick;
    assign CLOCK_OUT_PIN        = dif.clk_pin;
    assign CLOCK_SOURCE_MODE    = mode_ff;
    assign WATCHDOG_SLOW_SOURCE = wdog_ff;
    assign PLL_ENABLE           = (mode_ff == MODE_PLL) & ~power_down;
    assign PLL_MULT             = PLL_MULT_VAL;
    assign POWERED_DOWN         = power_down;

    // read data, captured in the setup phase
    always_comb begin
        pll_view    = 8'h00;
        pwr_view    = 8'h00;
        status_view = 8'h00;
        pll_view[MODE_LSB +: 2]    = mode_ff;
        pll_view[WDOG_BIT]         = wdog_ff;
        pwr_view[DIV_LSB +: 3]     = div_ff;
        pwr_view[FAST_IRQ_BOOST_BIT]         = fast_irq_boost_ff;
        pwr_view[OPMODE_LSB +: 3]  = opmode_ff;
        status_view[0]             = power_down;
        status_view[1]             = boost;
        status_view[4:2]           = div_eff;
        status_view[7:5]           = key_ff;
        nxt_rdata = rdata_ff;
        if (PSEL && !PENABLE) begin
            nxt_rdata = 32'h0000_0000;
            if (!PWRITE) begin
                case (PADDR)
                    ADDR_PLL_CONFIG: nxt_rdata[7:0] = pll_view;
                    ADDR_PWR_CONFIG: nxt_rdata[7:0] = pwr_view;
                    ADDR_STATUS:     nxt_rdata[7:0] = status_view;
                    default:         nxt_rdata      = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_clk_close;
        key_ff == KEY_CLK_HELD && acc_wr && PADDR == ADDR_CLK_KEY2 && wbyte == CLK_KEY2_VAL;
    endsequence

    sequence s_pwr_close;
        key_ff == KEY_PWR_HELD && acc_wr && PADDR == ADDR_PWR_KEY && wbyte == PWR_KEY2_VAL;
    endsequence

    a_div_after_reset: assert property ($past(SYS_RST) |-> div_ff == 3'h3 && fast_irq_boost_ff == 1'b0)
        else $error("divider not three after reset");

    a_direct_write_drop: assert property (
        (acc_wr && (PADDR == ADDR_PLL_CONFIG || PADDR == ADDR_PWR_CONFIG))
        |=> $stable(mode_ff) && $stable(wdog_ff) && $stable(div_ff) && $stable(fast_irq_boost_ff))
        else $error("configuration changed on a bare write");

    a_break_aborts: assert property (
        (key_ff == KEY_CLK_HELD && acc && !(acc_wr && PADDR == ADDR_CLK_KEY2))
        |=> key_ff != KEY_CLK_HELD && $stable(wdog_ff))
        else $error("clock key sequence survived an intrusion");

    a_wdog_commit: assert property (s_clk_close |=> wdog_ff == $past(pend_ff[WDOG_BIT]))
        else $error("watchdog source not loaded at closing key");

    a_mode_legal: assert property (mode_ff == MODE_PLL || mode_ff == MODE_EXT_CLK)
        else $error("clock mode holds a reserved code");

    a_opmode_legal: assert property (opmode_ff == OPMODE_NORMAL || opmode_ff == OPMODE_POWER_DOWN)
        else $error("operating mode holds a reserved code");

    a_div_commit: assert property (s_pwr_close |=> div_ff == $past(pend_ff[2:0]))
        else $error("divider not loaded at closing power key");

    a_wake_exit: assert property (
        (power_down && (EXT_INT_LINE_0 || EXT_INT_LINE_1 || TIMER2_WAKE || TIMER3_WAKE) && !pwr_commit)
        |=> !POWERED_DOWN)
        else $error("power-down not left on wake source");

    a_boost_full: assert property (
        (fast_irq_boost_ff && IRQ_IN_SERVICE && !power_down && mode_ff == MODE_PLL) [*2] |-> CORE_CLK_EN)
        else $error("core not at full speed during boosted service");

    // outside service a divided clock never pulses in two cycles in a row
    a_boost_return: assert property (
        (fast_irq_boost_ff && CORE_CLK_EN && !IRQ_IN_SERVICE && div_ff != 3'h0) |=> !CORE_CLK_EN)
        else $error("divider override outside service");

    a_pll_mult: assert property (PLL_ENABLE |-> PLL_MULT == 11'h560)
        else $error("pll multiplier wrong");
endmodule : ccpc_top

// >>> sim/ccpc_top_tb.sv
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %s expected %0h seen %0h", what, exp, got); end end
module ccpc_top_tb
    import ccpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic        pready, pslverr, e, core_en, clk_pin, wdog, pll_en, pdown;
    logic        ext_clk = 0, irq_svc = 0;
    logic [3:0]  wake = 0;
    logic [1:0]  src_mode;
    logic [10:0] pll_mult;
    int          miscompares = 0, n_compared = 0;

    always #50 clk = ~clk;

    ccpc_top u_ccpc_top (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EXTERNAL_CLOCK_INPUT(ext_clk), .EXT_INT_LINE_0(wake[0]), .EXT_INT_LINE_1(wake[1]),
        .TIMER2_WAKE(wake[2]), .TIMER3_WAKE(wake[3]), .IRQ_IN_SERVICE(irq_svc), .CORE_CLK_EN(core_en),
        .CLOCK_OUT_PIN(clk_pin), .CLOCK_SOURCE_MODE(src_mode), .WATCHDOG_SLOW_SOURCE(wdog),
        .PLL_ENABLE(pll_en), .PLL_MULT(pll_mult), .POWERED_DOWN(pdown));

    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic hang(input string what);
        $display("[ERR] %s expected done seen timeout", what);
        miscompares++;
        end_sim();
    endtask : hang

    // one apb transfer; the request holds until pready is seen at a rising edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel    <= 1;
        penable <= 0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) hang("pready");
        r = prdata;
        e = pslverr;
        psel    <= 0;
        penable <= 0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 0, 0);
        `CHK("read data", exp, r);
    endtask : rd_chk

    task automatic clk_cfg(input logic [31:0] v);
        apb(ADDR_CLK_KEY1, 1, {24'h0, CLK_KEY1_VAL});
        apb(ADDR_PLL_CONFIG, 1, v);
        apb(ADDR_CLK_KEY2, 1, {24'h0, CLK_KEY2_VAL});
        @(negedge clk);
    endtask : clk_cfg

    task automatic pwr_cfg(input logic [31:0] v);
        apb(ADDR_PWR_KEY, 1, {24'h0, PWR_KEY1_VAL});
        apb(ADDR_PWR_CONFIG, 1, v);
        apb(ADDR_PWR_KEY, 1, {24'h0, PWR_KEY2_VAL});
        @(negedge clk);
    endtask : pwr_cfg

    // cycles from one core clock pulse to the next, and pin-high cycles within them
    task automatic period(output int p, output int hi);
        int i;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (core_en !== 1'b1 && i < 400);
        if (i >= 400) hang("core pulse");
        p = 0;
        hi = 0;
        do begin
            @(negedge clk);
            p++;
            if (clk_pin === 1'b1) hi++;
        end while (core_en !== 1'b1 && p < 400);
    endtask : period

    task automatic t_reset;
        int p, hi;
        rd_chk(ADDR_PLL_CONFIG, {24'h0, 8'h01});
        rd_chk(ADDR_PWR_CONFIG, {24'h0, 8'h03});
        `CHK("pll mult", 11'd1376, pll_mult);
        `CHK("pll enable", 1'b1, pll_en);
        `CHK("watchdog source", 1'b0, wdog);
        period(p, hi);
        period(p, hi);
        `CHK("reset period", 8, p);
    endtask : t_reset

    task automatic t_div;
        int p, hi;
        for (int d = 0; d < 8; d++) begin
            pwr_cfg({29'h0, 3'(d)});
            period(p, hi);
            period(p, hi);
            `CHK("core period", 1 << d, p);
            `CHK("pin high cycles", (d == 0) ? 1 : 1 << (d - 1), hi);
        end
    endtask : t_div

    task automatic t_keys;
        clk_cfg(32'h05);
        rd_chk(ADDR_PLL_CONFIG, 32'h05);
        `CHK("watchdog source", 1'b1, wdog);
        apb(ADDR_PLL_CONFIG, 1, 32'h04);
        rd_chk(ADDR_PLL_CONFIG, 32'h05);
        apb(ADDR_CLK_KEY1, 1, {24'h0, CLK_KEY1_VAL});
        apb(ADDR_STATUS, 0, 0);
        apb(ADDR_PLL_CONFIG, 1, 32'h04);
        apb(ADDR_CLK_KEY2, 1, {24'h0, CLK_KEY2_VAL});
        rd_chk(ADDR_PLL_CONFIG, 32'h05);
        apb(ADDR_CLK_KEY1, 1, 32'hab);
        apb(ADDR_PLL_CONFIG, 1, 32'h04);
        apb(ADDR_CLK_KEY2, 1, {24'h0, CLK_KEY2_VAL});
        rd_chk(ADDR_PLL_CONFIG, 32'h05);
        apb(ADDR_PWR_KEY, 1, {24'h0, PWR_KEY1_VAL});
        apb(ADDR_PWR_CONFIG, 1, 32'h07);
        apb(ADDR_PWR_KEY, 1, {24'h0, CLK_KEY2_VAL});
        rd_chk(ADDR_PWR_CONFIG, 32'h03);
        apb(8'h40, 0, 0);
        `CHK("unmapped error", 1'b1, e);
        clk_cfg(32'h01);
        `CHK("watchdog source", 1'b0, wdog);
    endtask : t_keys

    task automatic t_ext;
        int n;
        pwr_cfg(32'h00);
        clk_cfg(32'h03);
        `CHK("source mode", 2'h3, src_mode);
        `CHK("pll enable", 1'b0, pll_en);
        n = 0;
        for (int i = 0; i < 44; i++) begin
            @(posedge clk);
            ext_clk <= (i >= 4 && i < 36) ? ((i % 4) < 2) : 1'b0;
            @(negedge clk);
            if (core_en === 1'b1) n++;
        end
        `CHK("external pulses", 8, n);
        clk_cfg(32'h00);
        clk_cfg(32'h02);
        rd_chk(ADDR_PLL_CONFIG, 32'h03);
        clk_cfg(32'h01);
        `CHK("source mode", 2'h1, src_mode);
        pwr_cfg(32'h03);
    endtask : t_ext

    task automatic t_pdown;
        int n;
        for (int w = 0; w < 4; w++) begin
            pwr_cfg(32'h13);
            `CHK("powered down", 1'b1, pdown);
            `CHK("pll enable", 1'b0, pll_en);
            n = 0;
            repeat (20) begin
                @(negedge clk);
                if (core_en !== 1'b0) n++;
            end
            `CHK("pulses while down", 0, n);
            rd_chk(ADDR_STATUS, {24'h0, 3'(KEY_IDLE), 5'h0d});
            @(posedge clk);
            wake[w] <= 1;
            @(posedge clk);
            wake <= 0;
            repeat (2) @(negedge clk);
            `CHK("powered down", 1'b0, pdown);
            rd_chk(ADDR_PWR_CONFIG, 32'h03);
        end
        pwr_cfg(32'h23);
        rd_chk(ADDR_PWR_CONFIG, 32'h03);
    endtask : t_pdown

    task automatic t_fast_irq_boost;
        int p, hi;
        pwr_cfg(32'h0b);
        @(posedge clk);
        irq_svc <= 1;
        period(p, hi);
        period(p, hi);
        `CHK("boosted period", 1, p);
        @(posedge clk);
        irq_svc <= 0;
        period(p, hi);
        period(p, hi);
        `CHK("resumed period", 8, p);
        pwr_cfg(32'h03);
        @(posedge clk);
        irq_svc <= 1;
        period(p, hi);
        period(p, hi);
        `CHK("unboosted period", 8, p);
        @(posedge clk);
        irq_svc <= 0;
    endtask : t_fast_irq_boost

    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 0;
        t_reset();
        t_keys();
        t_div();
        pwr_cfg(32'h03);
        t_ext();
        t_pdown();
        t_fast_irq_boost();
        end_sim();
    end
endmodule : ccpc_top_tb
